// File: logic/burst_sram_port.sv
`timescale 1ns/10ps
module burst_sram_port #(
  parameter int WORD_W = burst_port_pkg::WORD_W,
  parameter int ADDR_W = burst_port_pkg::ADDR_W,
  parameter int MEM_AW = burst_port_pkg::MEM_AW,
  parameter int CNT_W = burst_port_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic [WORD_W/burst_port_pkg::LANE_W-1:0] byte_lane_write_select_n,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_data_oe_n,
  output logic read_output_valid,
  output logic echo_clock_out,
  output logic echo_clock_out_n,
  output logic core_ready,
  output logic [CNT_W-1:0] read_bursts,
  output logic [CNT_W-1:0] write_bursts
);
  localparam int LANES = burst_port_pkg::lane_count(WORD_W);

  // --------------------------------------------------------------
  // core domain: ready flag and burst counters
  // --------------------------------------------------------------
  logic ready_r, ready_nxt;
  logic [1:0] tog_m;
  logic [1:0] tog_seen_r, tog_seen_nxt;
  logic [CNT_W-1:0] rd_cnt_r, rd_cnt_nxt;
  logic [CNT_W-1:0] wr_cnt_r, wr_cnt_nxt;
  logic rd_tog_r, rd_tog_nxt;
  logic wr_tog_r, wr_tog_nxt;

  always_comb begin
    ready_nxt = 1'b1;
    tog_seen_nxt = tog_m;
    rd_cnt_nxt = rd_cnt_r + CNT_W'(tog_m[0] ^ tog_seen_r[0]);
    wr_cnt_nxt = wr_cnt_r + CNT_W'(tog_m[1] ^ tog_seen_r[1]);
    if (!rst_b) begin
      ready_nxt = 1'b0;
      tog_seen_nxt = tog_m;
      rd_cnt_nxt = '0;
      wr_cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    ready_r <= ready_nxt;
    tog_seen_r <= tog_seen_nxt;
    rd_cnt_r <= rd_cnt_nxt;
    wr_cnt_r <= wr_cnt_nxt;
  end

  // burst toggles cross from the true-clock domain into the core clock
  sync2 #(.W(2)) u_tog_sync (
    .clk(mclk),
    .d({wr_tog_r, rd_tog_r}),
    .q(tog_m)
  );

  assign core_ready = ready_r;
  assign read_bursts = rd_cnt_r;
  assign write_bursts = wr_cnt_r;

  // --------------------------------------------------------------
  // true-clock domain
  // --------------------------------------------------------------
  logic rdy_k;
  burst_mem_if #(.W(WORD_W), .AW(MEM_AW), .LANES(LANES)) mif ();

  sync2 #(.W(1)) u_rdy_sync (
    .clk(k_clk),
    .d(ready_r),
    .q(rdy_k)
  );

  burst_mem #(.W(WORD_W), .AW(MEM_AW), .LANES(LANES)) u_mem (
    .clk(k_clk),
    .mif(mif.mem)
  );

  function automatic logic [WORD_W-1:0] word_of(input logic [4*WORD_W-1:0] b, input int i);
    return b[i*WORD_W +: WORD_W];
  endfunction : word_of

  logic rd_cmd, wr_cmd;
  logic fetch_r, fetch_nxt;
  burst_port_pkg::rd_phase_t rd_st_r, rd_st_nxt;
  logic [2*WORD_W-1:0] hold_r, hold_nxt;
  logic [WORD_W-1:0] q_even_r, q_even_nxt;
  logic oe_n_r, oe_n_nxt;
  logic valid_r, valid_nxt;
  logic ek_r, ek_nxt;
  logic arm_r, arm_nxt;
  burst_port_pkg::wr_phase_t wr_st_r, wr_st_nxt;
  logic [MEM_AW-1:0] wa_cmd_r, wa_cmd_nxt;
  logic [MEM_AW-1:0] wa_r, wa_nxt;
  logic [2*WORD_W-1:0] wd_k_r, wd_k_nxt;
  logic [2*LANES-1:0] we_k_r, we_k_nxt;

  // a command is refused in the cycle right after one of its own kind
  assign rd_cmd = rdy_k && !read_port_select_n && !fetch_r;
  assign wr_cmd = rdy_k && !write_port_select_n && !arm_r;

  always_comb begin
    fetch_nxt = rd_cmd;
    rd_tog_nxt = rd_tog_r ^ rd_cmd;
    hold_nxt = hold_r;
    q_even_nxt = q_even_r;
    if (fetch_r) begin
      rd_st_nxt = burst_port_pkg::RD_BEAT01;
      q_even_nxt = word_of(mif.rd_data, 0);
      hold_nxt = {word_of(mif.rd_data, 3), word_of(mif.rd_data, 2)};
    end else if (rd_st_r == burst_port_pkg::RD_BEAT01) begin
      rd_st_nxt = burst_port_pkg::RD_BEAT23;
      q_even_nxt = hold_r[WORD_W-1:0];
    end else begin
      rd_st_nxt = burst_port_pkg::RD_IDLE;
    end
    oe_n_nxt = (rd_st_nxt == burst_port_pkg::RD_IDLE);
    valid_nxt = (rd_st_nxt != burst_port_pkg::RD_IDLE);
    ek_nxt = !ek_r;
    if (!rdy_k) begin
      fetch_nxt = 1'b0;
      rd_tog_nxt = 1'b0;
      rd_st_nxt = burst_port_pkg::RD_IDLE;
      oe_n_nxt = 1'b1;
      valid_nxt = 1'b0;
      ek_nxt = 1'b0;
    end
  end

  always_ff @(posedge k_clk) begin
    fetch_r <= fetch_nxt;
    rd_tog_r <= rd_tog_nxt;
    rd_st_r <= rd_st_nxt;
    hold_r <= hold_nxt;
    q_even_r <= q_even_nxt;
    oe_n_r <= oe_n_nxt;
    valid_r <= valid_nxt;
    ek_r <= ek_nxt;
  end

  always_comb begin
    arm_nxt = wr_cmd;
    wr_tog_nxt = wr_tog_r ^ wr_cmd;
    wa_cmd_nxt = wa_cmd_r;
    wa_nxt = wa_r;
    wd_k_nxt = wd_k_r;
    we_k_nxt = we_k_r;
    if (wr_cmd) begin
      wa_cmd_nxt = addr[MEM_AW-1:0];
    end
    if (arm_r) begin
      wr_st_nxt = burst_port_pkg::WR_MID;
      wa_nxt = wa_cmd_r;
      wd_k_nxt[WORD_W-1:0] = wr_data;
      we_k_nxt[LANES-1:0] = ~byte_lane_write_select_n;
    end else if (wr_st_r == burst_port_pkg::WR_MID) begin
      wr_st_nxt = burst_port_pkg::WR_LAST;
      wd_k_nxt[2*WORD_W-1:WORD_W] = wr_data;
      we_k_nxt[2*LANES-1:LANES] = ~byte_lane_write_select_n;
    end else begin
      wr_st_nxt = burst_port_pkg::WR_IDLE;
    end
    if (!rdy_k) begin
      arm_nxt = 1'b0;
      wr_tog_nxt = 1'b0;
      wr_st_nxt = burst_port_pkg::WR_IDLE;
    end
  end

  always_ff @(posedge k_clk) begin
    arm_r <= arm_nxt;
    wr_tog_r <= wr_tog_nxt;
    wr_st_r <= wr_st_nxt;
    wa_cmd_r <= wa_cmd_nxt;
    wa_r <= wa_nxt;
    wd_k_r <= wd_k_nxt;
    we_k_r <= we_k_nxt;
  end

  // --------------------------------------------------------------
  // complementary-clock half: odd beats in and out
  // --------------------------------------------------------------
  logic [WORD_W-1:0] q_odd_r, q_odd_nxt;
  logic [2*WORD_W-1:0] wd_kb_r, wd_kb_nxt;
  logic [2*LANES-1:0] we_kb_r, we_kb_nxt;
  logic ekb_r, ekb_nxt;

  always_comb begin
    q_odd_nxt = q_odd_r;
    wd_kb_nxt = wd_kb_r;
    we_kb_nxt = we_kb_r;
    ekb_nxt = rdy_k ? ek_r : 1'b0;
    if (rd_st_r == burst_port_pkg::RD_BEAT01) begin
      q_odd_nxt = word_of(mif.rd_data, 1);
    end else if (rd_st_r == burst_port_pkg::RD_BEAT23) begin
      q_odd_nxt = hold_r[2*WORD_W-1:WORD_W];
    end
    if (wr_st_r == burst_port_pkg::WR_MID) begin
      wd_kb_nxt[WORD_W-1:0] = wr_data;
      we_kb_nxt[LANES-1:0] = ~byte_lane_write_select_n;
    end else if (wr_st_r == burst_port_pkg::WR_LAST) begin
      wd_kb_nxt[2*WORD_W-1:WORD_W] = wr_data;
      we_kb_nxt[2*LANES-1:LANES] = ~byte_lane_write_select_n;
    end
  end

  always_ff @(posedge k_n_clk) begin
    q_odd_r <= q_odd_nxt;
    wd_kb_r <= wd_kb_nxt;
    we_kb_r <= we_kb_nxt;
    ekb_r <= ekb_nxt;
  end

  // --------------------------------------------------------------
  // memory hookup and pins
  // --------------------------------------------------------------
  assign mif.rd_en = rd_cmd;
  assign mif.rd_addr = addr[MEM_AW-1:0];
  assign mif.wr_en = (wr_st_r == burst_port_pkg::WR_LAST);
  assign mif.wr_addr = wa_r;
  // word order 0..3: true beat, complementary beat, true beat, complementary beat
  assign mif.wr_data = {wd_kb_r[2*WORD_W-1:WORD_W], wd_k_r[2*WORD_W-1:WORD_W],
                        wd_kb_r[WORD_W-1:0], wd_k_r[WORD_W-1:0]};
  assign mif.wr_lane_en = {we_kb_r[2*LANES-1:LANES], we_k_r[2*LANES-1:LANES],
                           we_kb_r[LANES-1:0], we_k_r[LANES-1:0]};

  // high from a true rise until the next complementary rise
  assign echo_clock_out = ek_r ^ ekb_r;
  assign echo_clock_out_n = ~(ek_r ^ ekb_r);
  assign rd_data = (ek_r ^ ekb_r) ? q_even_r : q_odd_r;
  assign rd_data_oe_n = oe_n_r;
  assign read_output_valid = valid_r;
endmodule : burst_sram_port

// File: logic/burst_port_pkg.sv
package burst_port_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 21;
  localparam int LANE_W = 9;
  localparam int BURST_WORDS = 4;
  localparam int MEM_AW = 10;
  localparam int CNT_W = 16;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {RD_IDLE, RD_BEAT01, RD_BEAT23} rd_phase_t;
  typedef enum logic [1:0] {WR_IDLE, WR_MID, WR_LAST} wr_phase_t;

  function automatic int lane_count(input int w);
    return w / LANE_W;
  endfunction : lane_count
endpackage : burst_port_pkg

// File: logic/burst_mem_if.sv
`timescale 1ns/10ps
interface burst_mem_if #(
  parameter int W = 18,
  parameter int AW = 10,
  parameter int LANES = 2
);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [4*W-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [4*W-1:0] wr_data;
  logic [4*LANES-1:0] wr_lane_en;

  modport ctrl (output rd_en, output rd_addr, input rd_data,
                output wr_en, output wr_addr, output wr_data, output wr_lane_en);
  modport mem (input rd_en, input rd_addr, output rd_data,
               input wr_en, input wr_addr, input wr_data, input wr_lane_en);
endinterface : burst_mem_if

// File: logic/sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q_r <= meta_r;
  end

  assign q = q_r;
endmodule : sync2

// File: logic/burst_mem.sv
`timescale 1ns/10ps
module burst_mem #(
  parameter int W = 18,
  parameter int AW = 10,
  parameter int LANES = 2
) (
  input wire logic clk,
  burst_mem_if.mem mif
);
  logic [4*W-1:0] mem_r [2**AW];
  logic [4*W-1:0] rd_r;
  logic [4*W-1:0] merged;

  // --------------------------------------------------------------
  // lane merge of a whole burst
  // --------------------------------------------------------------
  always_comb begin
    merged = mem_r[mif.wr_addr];
    for (int i = 0; i < 4 * LANES; i++) begin
      if (mif.wr_lane_en[i]) begin
        merged[i*burst_port_pkg::LANE_W +: burst_port_pkg::LANE_W] =
          mif.wr_data[i*burst_port_pkg::LANE_W +: burst_port_pkg::LANE_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (mif.wr_en) begin
      mem_r[mif.wr_addr] <= merged;
    end
    if (mif.rd_en) begin
      rd_r <= mem_r[mif.rd_addr];
    end
  end

  assign mif.rd_data = rd_r;
endmodule : burst_mem

// File: tb/burst_sram_port_assertions.sv
`timescale 1ns/10ps
module burst_sram_port_assertions #(
  parameter int CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic k_clk,
  input wire logic k_n_clk,
  input wire logic read_port_select_n,
  input wire logic rd_data_oe_n,
  input wire logic read_output_valid,
  input wire logic echo_clock_out,
  input wire logic echo_clock_out_n,
  input wire logic core_ready,
  input wire logic [CNT_W-1:0] read_bursts,
  input wire logic [CNT_W-1:0] write_bursts
);
  // ----
  // read sequences
  // ----
  sequence rd_take;
    $fell(read_port_select_n);
  endsequence
  sequence rd_beats;
    read_output_valid [*2];
  endsequence
  ready_up_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(rst_b) |-> core_ready) else $error("core ready missing");
  rd_burst_a: assert property (@(posedge k_clk) disable iff (!rst_b)
    rd_take ##1 read_port_select_n |=> rd_beats ##1 !read_output_valid)
    else $error("read burst length wrong");
  rd_refuse_a: assert property (@(posedge k_clk) disable iff (!rst_b)
    rd_take ##1 !read_port_select_n ##1 read_port_select_n
    |=> read_output_valid ##1 !read_output_valid) else $error("early read taken");
  valid_cause_a: assert property (@(posedge k_clk) disable iff (!rst_b)
    $rose(read_output_valid) |-> $past(read_port_select_n, 2) == 1'h0)
    else $error("valid without read");
  valid_drive_a: assert property (@(posedge k_clk) disable iff (!rst_b)
    read_output_valid == !rd_data_oe_n) else $error("drive and valid differ");
  echo_hi_a: assert property (@(posedge k_n_clk) disable iff (!rst_b)
    read_output_valid |-> echo_clock_out && !echo_clock_out_n) else $error("echo not high");
  echo_lo_a: assert property (@(posedge k_clk) disable iff (!rst_b)
    read_output_valid && $past(read_output_valid) |-> !echo_clock_out && echo_clock_out_n)
    else $error("echo not low");
  count_up_a: assert property (@(posedge mclk) disable iff (!rst_b)
    read_bursts >= $past(read_bursts) && write_bursts >= $past(write_bursts))
    else $error("burst count fell");
endmodule : burst_sram_port_assertions

bind burst_sram_port burst_sram_port_assertions #(.CNT_W(CNT_W)) i_burst_sram_port_assertions (
  .mclk, .rst_b, .k_clk, .k_n_clk, .read_port_select_n, .rd_data_oe_n, .read_output_valid,
  .echo_clock_out, .echo_clock_out_n, .core_ready, .read_bursts, .write_bursts);

// File: tb/burst_ctrl_model.sv
`timescale 1ns/10ps
module burst_ctrl_model (
  output logic k_clk,
  output logic k_n_clk,
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [20:0] addr,
  output logic [17:0] wr_data,
  output logic [1:0] byte_lane_write_select_n,
  input wire logic [17:0] rd_data,
  input wire logic read_output_valid
);
  // ----
  // controller side
  // ----
  assign k_n_clk = ~k_clk;
  initial begin
    write_port_select_n = 1'h1;
    read_port_select_n = 1'h1;
    addr = 21'h0;
    wr_data = 18'h0;
    byte_lane_write_select_n = 2'h3;
    k_clk = 1'h0;
    #7;
    forever #24 k_clk = ~k_clk;
  end
  task automatic write_burst(input logic [20:0] a, input logic [71:0] w, input logic [7:0] b);
    @(posedge k_clk);
    write_port_select_n <= 1'h0;
    addr <= a;
    @(posedge k_clk);
    write_port_select_n <= 1'h1;
    addr <= ~a;
    for (int i = 0; i < 4; i++) begin
      wr_data <= w[18*i +: 18];
      byte_lane_write_select_n <= b[2*i +: 2];
      if (i % 2 == 0) @(posedge k_clk);
      else @(posedge k_n_clk);
    end
    wr_data <= ~wr_data;
    byte_lane_write_select_n <= 2'h0;
  endtask : write_burst
  task automatic read_burst(input logic [20:0] a, input logic twice,
                            output logic [71:0] got, output logic [4:0] vld);
    @(posedge k_clk);
    read_port_select_n <= 1'h0;
    addr <= a;
    @(posedge k_clk);
    read_port_select_n <= ~twice;
    addr <= ~a;
    @(posedge k_clk);
    read_port_select_n <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      #12;
      vld[i] = read_output_valid;
      if (i < 4) got[18*i +: 18] = rd_data;
      if (i % 2 == 0) @(posedge k_n_clk);
      else @(posedge k_clk);
    end
  endtask : read_burst
endmodule : burst_ctrl_model

// File: tb/burst_sram_port_bench.sv
`timescale 1ns/10ps
module burst_sram_port_bench;
  typedef logic [71:0] burst_t;
  localparam burst_t BURST_A = 72'h0123456789abcdef01;
  localparam burst_t BURST_B = 72'hfedcba9876543210fe;
  logic mclk, rst_b, k_clk, k_n_clk, write_port_select_n, read_port_select_n;
  logic [burst_port_pkg::ADDR_W-1:0] addr;
  logic [burst_port_pkg::WORD_W-1:0] wr_data, rd_data;
  logic [1:0] byte_lane_write_select_n;
  logic rd_data_oe_n, read_output_valid, echo_clock_out, echo_clock_out_n, core_ready;
  logic [15:0] read_bursts, write_bursts;
  int num_errors, total_checks;
  burst_sram_port i_burst_sram_port (.mclk, .rst_b, .k_clk, .k_n_clk, .write_port_select_n,
    .read_port_select_n, .addr, .wr_data, .byte_lane_write_select_n, .rd_data, .rd_data_oe_n,
    .read_output_valid, .echo_clock_out, .echo_clock_out_n, .core_ready, .read_bursts,
    .write_bursts);
  burst_ctrl_model i_burst_ctrl_model (.k_clk, .k_n_clk, .write_port_select_n,
    .read_port_select_n, .addr, .wr_data, .byte_lane_write_select_n, .rd_data,
    .read_output_valid);
  // ----
  // scenarios
  // ----
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  task automatic close_out;
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string what, input burst_t exp, input burst_t got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_ready;
    for (int i = 0; i < 20 && core_ready !== 1'h1; i++) @(posedge mclk);
    if (core_ready !== 1'h1) begin
      num_errors++;
      close_out();
    end else begin
      repeat (5) @(posedge mclk);
    end
  endtask : wait_ready
  task automatic full_burst;
    burst_t got;
    logic [4:0] vld;
    i_burst_ctrl_model.write_burst(21'h1c0005, BURST_A, 8'h00);
    i_burst_ctrl_model.read_burst(21'h1c0005, 1'h0, got, vld);
    check("read data", BURST_A, got);
    check("valid beats", 72'h0f, vld);
  endtask : full_burst
  task automatic lane_mask;
    burst_t got, exp;
    logic [4:0] vld;
    for (int i = 0; i < 8; i++) exp[9*i +: 9] = i % 3 ? BURST_B[9*i +: 9] : BURST_A[9*i +: 9];
    i_burst_ctrl_model.write_burst(21'h1c0005, BURST_B, 8'h49);
    i_burst_ctrl_model.read_burst(21'h1c0005, 1'h0, got, vld);
    check("lane data", exp, got);
  endtask : lane_mask
  task automatic refuse_read;
    burst_t got;
    logic [4:0] vld;
    i_burst_ctrl_model.read_burst(21'h1c0005, 1'h1, got, vld);
    check("held read valid", 72'h0f, vld);
  endtask : refuse_read
  initial begin
    rst_b = 1'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    check("reset state", 72'h0, {core_ready, read_bursts, write_bursts});
    @(posedge mclk);
    rst_b <= 1'h1;
    wait_ready();
    full_burst();
    lane_mask();
    refuse_read();
    repeat (6) @(posedge mclk);
    check("burst counts", {16'h3, 16'h2}, {read_bursts, write_bursts});
    close_out();
  end
endmodule : burst_sram_port_bench
